// ==== src/ddsl_map.svh ====
// Purpose: Named constants for the dual channel serial load block
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef DDSL_MAP_SVH
`define DDSL_MAP_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define DDSL_WORD_W    16
`define DDSL_CODE_W    14
`define DDSL_ADDR_HI   15
`define DDSL_ADDR_LO   14
`define DDSL_CODE_MSB  13
`define DDSL_SHIFT_TOP 14

// ----------------------------------------------------------------
// Preset and reset values
// ----------------------------------------------------------------
`define DDSL_CODE_ZERO 14'h0000
`define DDSL_CODE_HALF 14'h2000
`define DDSL_WORD_RST  16'h0000

// ----------------------------------------------------------------
// Bit counter
// ----------------------------------------------------------------
`define DDSL_CNT_W     5
`define DDSL_CNT_ZERO  5'h00
`define DDSL_CNT_ONE   5'h01
`define DDSL_CNT_FULL  5'h10

`endif

// ==== src/ddsl_pkg.sv ====
// Purpose: Types for the dual channel serial load block
// Assumes: Nothing is imported; users write ddsl_pkg::name
// Notes:   Gray coded states along idle, shift, load
package ddsl_pkg;

	// ------------------------------------------------------------
	// Frame sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DDSL_IDLE  = 2'h0,
		DDSL_SHIFT = 2'h1,
		DDSL_LOAD  = 2'h3
	} ddsl_state_t;

	// ------------------------------------------------------------
	// Channel address codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DDSL_SEL_NONE = 2'h0,
		DDSL_SEL_A    = 2'h1,
		DDSL_SEL_B    = 2'h2,
		DDSL_SEL_BOTH = 2'h3
	} ddsl_sel_t;

endpackage

// ==== src/ddsl_top.sv ====
// Purpose: Serial load interface of a dual channel converter
// Assumes: Link pins are synchronous to mclk; serial clock is
//          slower than mclk/2 so every edge is seen
// Notes:   Channel codes come from flip-flops
//
// Notes on behaviour
// - Words arrive on chip select, data and serial clock into a 16-bit shift register.
// - Words go most significant bit first, each new bit entering at bit 0.
// - Data is sampled on each rising edge of the serial clock.
// - The shift register moves only while chip select is low.
// - On chip select rising only the last 16 bits shifted count.
// - Chip select rising after 16 or more bits fires a load strobe copying the code to selected channels.
// - Bit 15 is the upper address bit, bit 14 the lower, bits 13 to 0 the code.
// - Address 00 loads none, 01 the first, 10 the second, 11 both channels.
// - Active preset forces all channel codes to zero or to half scale.
`timescale 1ns/1ps
`include "ddsl_map.svh"

module ddsl_top (
	// Clock, reset, enable
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	input  wire logic                     clk_en,
	// Serial link
	input  wire logic                     cs_n,
	input  wire logic                     sdi,
	input  wire logic                     sclk,
	// Preset control
	input  wire logic                     preset_force_n,
	input  wire logic                     preset_half,
	// Channel codes and status
	output logic      [`DDSL_CODE_W-1:0]  code_a,
	output logic      [`DDSL_CODE_W-1:0]  code_b,
	output logic                          load_stb,
	output logic                          busy
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	ddsl_pkg::ddsl_state_t     state_q;
	ddsl_pkg::ddsl_state_t     state_d;
	logic [`DDSL_WORD_W-1:0]   sr_q;
	logic [`DDSL_CNT_W-1:0]    cnt_q;
	logic [`DDSL_CODE_W-1:0]   code_a_q;
	logic [`DDSL_CODE_W-1:0]   code_b_q;
	logic [`DDSL_CODE_W-1:0]   preset_val;
	logic [`DDSL_CODE_W-1:0]   word_code;
	ddsl_pkg::ddsl_sel_t       word_sel;
	logic                      sclk_q;
	logic                      cs_n_q;
	logic                      sclk_rise;
	logic                      cs_rise;
	logic                      shift_ev;
	logic                      load_go;
	logic                      sel_a;
	logic                      sel_b;

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else if (clk_en) begin
			sclk_q <= sclk;
			cs_n_q <= cs_n;
		end
	end

	assign sclk_rise = sclk & ~sclk_q;
	assign cs_rise   = cs_n & ~cs_n_q;
	// Gated on the live and the delayed select, so an edge that
	// coincides with chip select rising is dropped
	assign shift_ev  = clk_en & sclk_rise & ~cs_n & ~cs_n_q;

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ddsl_pkg::DDSL_IDLE: begin
				if (!cs_n) begin
					state_d = ddsl_pkg::DDSL_SHIFT;
				end
			end
			ddsl_pkg::DDSL_SHIFT: begin
				// Short frames are dropped rather than loading stale bits
				if (cs_rise && cnt_q == `DDSL_CNT_FULL) begin
					state_d = ddsl_pkg::DDSL_LOAD;
				end else if (cs_rise) begin
					state_d = ddsl_pkg::DDSL_IDLE;
				end
			end
			ddsl_pkg::DDSL_LOAD: begin
				state_d = ddsl_pkg::DDSL_IDLE;
			end
			default: begin
				state_d = ddsl_pkg::DDSL_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ddsl_pkg::DDSL_IDLE;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Shift register and bit count
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sr_q <= `DDSL_WORD_RST;
		end else if (shift_ev) begin
			// Older surplus bits fall off the top
			sr_q <= {sr_q[`DDSL_SHIFT_TOP:0], sdi};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= `DDSL_CNT_ZERO;
		end else if (clk_en && state_q == ddsl_pkg::DDSL_IDLE) begin
			cnt_q <= `DDSL_CNT_ZERO;
		end else if (shift_ev && cnt_q != `DDSL_CNT_FULL) begin
			cnt_q <= cnt_q + `DDSL_CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// Decode and channel registers
	// ------------------------------------------------------------
	assign word_sel  = ddsl_pkg::ddsl_sel_t'(
		{sr_q[`DDSL_ADDR_HI], sr_q[`DDSL_ADDR_LO]});
	assign word_code = sr_q[`DDSL_CODE_MSB:0];
	assign sel_a     = word_sel == ddsl_pkg::DDSL_SEL_A ||
		word_sel == ddsl_pkg::DDSL_SEL_BOTH;
	assign sel_b     = word_sel == ddsl_pkg::DDSL_SEL_B ||
		word_sel == ddsl_pkg::DDSL_SEL_BOTH;
	assign load_go   = clk_en && state_q == ddsl_pkg::DDSL_LOAD;
	assign preset_val = preset_half ? `DDSL_CODE_HALF : `DDSL_CODE_ZERO;

	// Preset wins over a load and ignores clk_en, so it acts at
	// the next mclk edge whatever else is going on
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			code_a_q <= `DDSL_CODE_ZERO;
		end else if (!preset_force_n) begin
			code_a_q <= preset_val;
		end else if (load_go && sel_a) begin
			code_a_q <= word_code;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			code_b_q <= `DDSL_CODE_ZERO;
		end else if (!preset_force_n) begin
			code_b_q <= preset_val;
		end else if (load_go && sel_b) begin
			code_b_q <= word_code;
		end
	end

	assign code_a   = code_a_q;
	assign code_b   = code_b_q;
	assign load_stb = state_q == ddsl_pkg::DDSL_LOAD;
	assign busy     = state_q == ddsl_pkg::DDSL_SHIFT;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_frame_end;
		clk_en && state_q == ddsl_pkg::DDSL_SHIFT && cs_rise &&
			cnt_q == `DDSL_CNT_FULL;
	endsequence

	sequence s_strobe;
		load_stb && !busy;
	endsequence

	property p_shift_msb_first;
		@(posedge mclk) disable iff (!nrst)
		shift_ev |=> sr_q == {$past(sr_q[`DDSL_SHIFT_TOP:0]), $past(sdi)};
	endproperty
	a_shift_msb_first: assert property (p_shift_msb_first)
		else $error("shift register did not take sdi at bit 0");

	property p_no_shift_off_edge;
		@(posedge mclk) disable iff (!nrst)
		!(clk_en && sclk_rise) |=> $stable(sr_q);
	endproperty
	a_no_shift_off_edge: assert property (p_no_shift_off_edge)
		else $error("shift register moved without a rising sclk");

	property p_no_shift_cs_high;
		@(posedge mclk) disable iff (!nrst)
		cs_n |=> $stable(sr_q);
	endproperty
	a_no_shift_cs_high: assert property (p_no_shift_cs_high)
		else $error("shift register moved while chip select high");

	property p_count_step;
		@(posedge mclk) disable iff (!nrst)
		shift_ev && cnt_q < `DDSL_CNT_FULL &&
			state_q == ddsl_pkg::DDSL_SHIFT |=>
			cnt_q == $past(cnt_q) + `DDSL_CNT_ONE;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("bit count did not advance on a shift");

	property p_count_sat;
		@(posedge mclk) disable iff (!nrst)
		cnt_q == `DDSL_CNT_FULL && state_q == ddsl_pkg::DDSL_SHIFT &&
			!cs_rise |=> cnt_q == `DDSL_CNT_FULL;
	endproperty
	a_count_sat: assert property (p_count_sat)
		else $error("bit count left full during surplus bits");

	property p_strobe_after_frame;
		@(posedge mclk) disable iff (!nrst)
		s_frame_end |=> s_strobe ##1 !load_stb;
	endproperty
	a_strobe_after_frame: assert property (p_strobe_after_frame)
		else $error("load strobe missing or longer after frame end");

	property p_load_a;
		@(posedge mclk) disable iff (!nrst)
		load_go && preset_force_n && sr_q[`DDSL_ADDR_LO] |=>
			code_a == $past(sr_q[`DDSL_CODE_MSB:0]);
	endproperty
	a_load_a: assert property (p_load_a)
		else $error("first channel did not take the code field");

	property p_load_b;
		@(posedge mclk) disable iff (!nrst)
		load_go && preset_force_n && sr_q[`DDSL_ADDR_HI] |=>
			code_b == $past(sr_q[`DDSL_CODE_MSB:0]);
	endproperty
	a_load_b: assert property (p_load_b)
		else $error("second channel did not take the code field");

	property p_unselected_hold;
		@(posedge mclk) disable iff (!nrst)
		preset_force_n && !(load_go && sel_a) |=> $stable(code_a);
	endproperty
	a_unselected_hold: assert property (p_unselected_hold)
		else $error("first channel changed without being selected");

	property p_preset;
		@(posedge mclk) disable iff (!nrst)
		!preset_force_n |=> code_a == $past(preset_val) &&
			code_b == $past(preset_val);
	endproperty
	a_preset: assert property (p_preset)
		else $error("preset did not force both channel codes");

endmodule

// ==== tb/ddsl_host_model.sv ====
// Purpose: Host side of the serial load link
// Assumes: Driven shortly after mclk rising edges
// Notes:   Each sclk level lasts two mclk cycles
`timescale 1ns/1ps

module ddsl_host_model (
	// Clock
	input  wire logic mclk,
	// Serial link
	output logic      cs_n,
	output logic      sdi,
	output logic      sclk
);
	initial begin
		cs_n = 1'b1;
		sdi  = 1'b0;
		sclk = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// ------------------------------------------------------------
	// Frame: low n bits of w, oldest first; gap idles after a byte
	// ------------------------------------------------------------
	task automatic xfer(input logic [31:0] w, input int n, input int gap);
		step(1);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			sdi  = w[i];
			step(2);
			sclk = 1'b1;
			step(2);
			if (i == 8 && gap > 0) begin
				sclk = 1'b0;
				step(gap);
			end
		end
		sclk = 1'b0;
		step(1);
		cs_n = 1'b1;
		// No pull on the data line, so show a changed level
		sdi  = ~sdi;
		step(3);
	endtask

	// Clock pulses while deselected
	task automatic idle(input int n);
		repeat (n) begin
			sclk = 1'b1;
			sdi  = ~sdi;
			step(2);
			sclk = 1'b0;
			step(2);
		end
	endtask

endmodule

// ==== tb/test_dual_dac_serial_load.sv ====
// Purpose: Self-checking bench for the serial load block
// Assumes: Host model drives the link pins
// Notes:   Expected codes tracked from address decode
`timescale 1ns/1ps

module test_dual_dac_serial_load;
	logic        mclk, nrst, clk_en, preset_force_n, preset_half;
	logic        cs_n, sdi, sclk, load_stb, busy;
	logic [13:0] code_a, code_b, exp_a, exp_b;
	int          bad_count, tests_run, stb_seen;

	ddsl_host_model host (.mclk(mclk), .cs_n(cs_n), .sdi(sdi), .sclk(sclk));

	ddsl_top uut (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .cs_n(cs_n),
		.sdi(sdi), .sclk(sclk), .preset_force_n(preset_force_n),
		.preset_half(preset_half), .code_a(code_a), .code_b(code_b),
		.load_stb(load_stb), .busy(busy)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (load_stb === 1'b1)
			stb_seen++;
	end

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen,
			input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic codes();
		chk("code_a", {2'h0, code_a}, {2'h0, exp_a});
		chk("code_b", {2'h0, code_b}, {2'h0, exp_b});
	endtask

	// es: expected strobes, -1 skips that check
	task automatic frame(input logic [31:0] w, input int n, input int gap,
			input bit upd, input int es);
		int s0;
		int k;
		s0 = stb_seen;
		host.xfer(w, n, gap);
		k = 0;
		while (busy !== 1'b0 && k < 10) begin
			host.step(1);
			k++;
		end
		if (k == 10) begin
			bad_count++;
			print_verdict();
		end
		if (upd && w[14]) exp_a = w[13:0];
		if (upd && w[15]) exp_b = w[13:0];
		codes();
		if (es >= 0)
			chk("strobes", 16'(stb_seen - s0), 16'(es));
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	logic [15:0] tbl [4] = '{16'h5555, 16'hAAAA, 16'hFFFF, 16'h0123};

	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		preset_force_n = 1'b1;
		preset_half = 1'b0;
		exp_a = 14'h0000;
		exp_b = 14'h0000;
		repeat (10) @(posedge mclk);
		#1;
		nrst = 1'b1;
		host.step(1);
		codes();
		foreach (tbl[i])
			frame({16'h0000, tbl[i]}, 16, 0, 1, 1);
		frame(32'h000E4ABC, 20, 0, 1, 1);
		frame(32'h0000C111, 12, 0, 0, 0);
		host.idle(4);
		codes();
		frame(32'h0000BFED, 16, 5, 1, 1);
		clk_en = ~clk_en;
		frame(32'h0000C000, 16, 0, 0, 0);
		clk_en = ~clk_en;
		preset_half = ~preset_half;
		preset_force_n = ~preset_force_n;
		host.step(2);
		exp_a = 14'h2000;
		exp_b = 14'h2000;
		codes();
		frame(32'h0000C555, 16, 0, 0, -1);
		preset_half = ~preset_half;
		host.step(2);
		exp_a = 14'h0000;
		exp_b = 14'h0000;
		codes();
		preset_force_n = ~preset_force_n;
		frame(32'h0000FFFF, 16, 0, 1, 1);
		nrst = 1'b0;
		host.step(2);
		exp_a = 14'h0000;
		exp_b = 14'h0000;
		codes();
		nrst = 1'b1;
		host.step(2);
		codes();
		chk("busy", {15'h0000, busy}, 16'h0000);
		chk("load_stb", {15'h0000, load_stb}, 16'h0000);
		print_verdict();
	end

endmodule
